// ### src/pmdb_pkg.sv
// Package for the peripheral module disable bank.
// Assumes byte-wide registers placed one per Wishbone word.
package pmdb_pkg;
  // Register indices as printed; the byte address is four times the index
  localparam logic [11:0] PMDB_IDX_CTRL0 = 12'h796;
  localparam logic [11:0] PMDB_IDX_CTRL1 = 12'h797;
  localparam logic [11:0] PMDB_IDX_CTRL2 = 12'h798;
  localparam logic [11:0] PMDB_IDX_CTRL3 = 12'h799;
  localparam logic [11:0] PMDB_IDX_CTRL4 = 12'h79a;
  localparam logic [11:0] PMDB_IDX_CTRL5 = 12'h79b;
  localparam logic [11:0] PMDB_IDX_CTRL6 = 12'h79c;
  localparam logic [11:0] PMDB_IDX_CTRL7 = 12'h79d;
  localparam int          PMDB_NREG      = 8;
  // Writable bit masks, unimplemented positions clear
  localparam logic [7:0] PMDB_MASK0 = 8'hc7;
  localparam logic [7:0] PMDB_MASK1 = 8'h7f;
  localparam logic [7:0] PMDB_MASK2 = 8'h80;
  localparam logic [7:0] PMDB_MASK3 = 8'h67;
  localparam logic [7:0] PMDB_MASK4 = 8'h6f;
  localparam logic [7:0] PMDB_MASK5 = 8'h60;
  localparam logic [7:0] PMDB_MASK6 = 8'h11;
  localparam logic [7:0] PMDB_MASK7 = 8'h3f;
  localparam logic [7:0] PMDB_RESET = 8'h00;
  // Field positions in control register 0
  localparam int PMDB_B_SYSCLK = 7;
  localparam int PMDB_B_VREF   = 6;
  localparam int PMDB_B_MEM    = 2;
  localparam int PMDB_B_REFCLK = 1;
  localparam int PMDB_B_PINCHG = 0;
  // Register 2..7 field positions
  localparam int PMDB_B_NCO    = 7;
  localparam int PMDB_B_DAC    = 6;
  localparam int PMDB_B_ADC    = 5;
  localparam int PMDB_B_CMP2   = 2;
  localparam int PMDB_B_CMP1   = 1;
  localparam int PMDB_B_ZCD    = 0;
  localparam int PMDB_B_PWM7   = 6;
  localparam int PMDB_B_PWM6   = 5;
  localparam int PMDB_B_WG2    = 6;
  localparam int PMDB_B_WG1    = 5;
  localparam int PMDB_B_ASER   = 4;
  localparam int PMDB_B_SSER   = 0;
  localparam int PMDB_B_SMT    = 5;
  localparam int PMDB_B_DSM    = 0;
  // Wake-up guard after re-enable: one instruction cycle, 4 system clocks
  localparam int PMDB_WAKE_CYC = 4;
  // Memory controller settle time after re-enable, in ns
  localparam int PMDB_MEM_WAKE_NS = 1000;
  localparam int PMDB_CLK_NS      = 20;
  localparam int PMDB_MEM_WAKE_CYC = PMDB_MEM_WAKE_NS / PMDB_CLK_NS;
endpackage : pmdb_pkg

// ### src/pmdb_wake.sv
// Per-module re-enable stretcher: holds a release-pending flag for a
// fixed number of cycles after a disable bit falls.
// Assumes the disable level is from the same clock domain.
`timescale 1ns/1ps
`default_nettype none
module pmdb_wake #(
  parameter int CYC = 4                 // Countdown length; held reset lasts one cycle longer after enable
) (
  input  wire logic clk_i,              // System clock
  input  wire logic rst_i,              // Synchronous reset
  input  wire logic off_i,              // Disable level from the bank
  output logic      hold_o              // Module still in reset
);
  localparam int CW = $clog2(CYC + 1);
  logic [CW-1:0] cnt_ff;                // Remaining held cycles
  logic          off_d_ff;              // Previous disable level

  // Count down after the falling edge of the disable bit
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_ff   <= '0;
      off_d_ff <= 1'b0;
    end else begin
      off_d_ff <= off_i;
      if (off_i) begin
        cnt_ff <= '0;
      end else if (off_d_ff) begin
        cnt_ff <= CW'(CYC);
      end else if (cnt_ff != '0) begin
        cnt_ff <= cnt_ff - 1'b1;
      end
    end
  end

  // Reset held while disabled and for the release window
  assign hold_o = off_i | off_d_ff | (cnt_ff != '0);
endmodule : pmdb_wake
`default_nettype wire

// ### src/pmdb_bank.sv
// Peripheral module disable bank: eight byte registers on classic
// Wishbone, driving clock gates and held resets for each peripheral.
// Assumes peripherals honour the gate and reset levels given here and
// forward their own register traffic through the filter ports below.
// Functional notes
// - Bit 7 reg0 stops peripheral system clock
// - Bit 6 reg0 disables voltage reference
// - Bit 2 reg0 blocks memory controller access
// - Bit 1 reg0 disables reference clock output
// - Bit 0 reg0 disables pin-change interrupts
// - Reg1 bits 0..6 disable timers 0..6
// - Reg2 bit 7 disables numeric oscillator
// - Reg3 disables DAC ADC comparators zero-cross
// - Reg4 disables PWM and capture units
// - Reg5 disables both waveform generators
// - Reg6 disables async and sync serial
// - Reg7 disables measure timer, cells, modulator
// - All disable bits reset to zero
// - Disabled module gated, reset, reads zero; measurement timer only gated and reset
// - Re-enabled module restarts from reset state
`timescale 1ns/1ps
`default_nettype none
module pmdb_bank #(
  parameter int WAKE_CYC     = pmdb_pkg::PMDB_WAKE_CYC,
  parameter int MEM_WAKE_CYC = pmdb_pkg::PMDB_MEM_WAKE_CYC
) (
  input  wire logic        clk_i,          // System clock, 50 MHz
  input  wire logic        rst_i,          // Synchronous reset
  // Wishbone classic slave
  input  wire logic        wb_cyc_i,       // Bus cycle
  input  wire logic        wb_stb_i,       // Strobe
  input  wire logic        wb_we_i,        // Write enable
  input  wire logic [13:0] wb_adr_i,       // Byte address
  input  wire logic [3:0]  wb_sel_i,       // Byte lanes
  input  wire logic [31:0] wb_dat_i,       // Write data
  output logic [31:0]      wb_dat_o,       // Read data
  output logic             wb_ack_o,       // Acknowledge
  // Clock network and per-module gate enables, high runs the clock
  output logic             sysclk_en_o,    // Peripheral system clock
  output logic             vref_clk_en_o,
  output logic             mem_clk_en_o,
  output logic             refclk_clk_en_o,
  output logic             pinchg_clk_en_o,
  output logic [6:0]       timer_clk_en_o,
  output logic             nco_clk_en_o,
  output logic [4:0]       ana_clk_en_o,   // zcd,cmp1,cmp2,adc,dac
  output logic [5:0]       pwm_clk_en_o,   // ccp1..4,pwm6,pwm7
  output logic [1:0]       wavegen_clk_en_o,
  output logic [1:0]       serial_clk_en_o, // sync, async
  output logic [5:0]       logic_clk_en_o, // dsm,cell1..4,smt
  // Held resets, high holds the module in reset
  output logic             vref_rst_o,
  output logic             mem_rst_o,
  output logic             refclk_rst_o,
  output logic             pinchg_rst_o,
  output logic [6:0]       timer_rst_o,
  output logic             nco_rst_o,
  output logic [4:0]       ana_rst_o,
  output logic [5:0]       pwm_rst_o,
  output logic [1:0]       wavegen_rst_o,
  output logic [1:0]       serial_rst_o,
  output logic [5:0]       logic_rst_o,
  // Peripheral register access filter, flat index of 32 modules, measurement timer not included
  input  wire logic [31:0] mod_wr_req_i,   // Write attempt per module
  output logic [31:0]      mod_wr_ok_o,    // Write allowed per module
  input  wire logic [255:0] mod_rd_dat_i,  // Read byte per module
  output logic [255:0]     mod_rd_dat_o,   // Filtered read byte
  input  wire logic [31:0] mod_dout_i,     // Digital output per module
  output logic [31:0]      mod_dout_o,     // Filtered digital output
  // Memory controller path
  input  wire logic        mem_req_i,      // Memory read/write request
  output logic             mem_grant_o,    // Request may proceed
  input  wire logic        mem_ctl_wr_i,   // Control register write
  output logic             mem_ctl_wr_ok_o,
  input  wire logic [7:0]  mem_ptr_rd_i,   // Indirect pointer read data
  output logic [7:0]       mem_ptr_rd_o,   // Forced zero when off
  output logic             mem_ready_o     // Settle time has elapsed
);
  logic [7:0] reg_ff [pmdb_pkg::PMDB_NREG]; // Disable bytes
  logic       ack_ff;                       // One-cycle acknowledge
  logic [31:0] rdat_ff;                     // Registered read data
  logic [7:0]  mask [pmdb_pkg::PMDB_NREG];  // Implemented bits
  logic [11:0] idx;                         // Word index
  logic [2:0]  sel_reg;                     // Register number
  logic        hit;                         // Address maps to bank
  logic        acc;                         // New access this cycle
  logic [31:0] off_vec;                     // Flat per-module disable
  logic [31:0] hold_vec;                    // Flat per-module reset
  logic        smt_hold;                    // Stretched reset, meas timer
  logic [$clog2(MEM_WAKE_CYC+1)-1:0] mem_cnt_ff; // Memory settle count

  assign mask[0] = pmdb_pkg::PMDB_MASK0;
  assign mask[1] = pmdb_pkg::PMDB_MASK1;
  assign mask[2] = pmdb_pkg::PMDB_MASK2;
  assign mask[3] = pmdb_pkg::PMDB_MASK3;
  assign mask[4] = pmdb_pkg::PMDB_MASK4;
  assign mask[5] = pmdb_pkg::PMDB_MASK5;
  assign mask[6] = pmdb_pkg::PMDB_MASK6;
  assign mask[7] = pmdb_pkg::PMDB_MASK7;

  // Address decode: index is the word address
  assign idx = wb_adr_i[13:2];
  assign hit = (idx >= pmdb_pkg::PMDB_IDX_CTRL0) &&
               (idx <= pmdb_pkg::PMDB_IDX_CTRL7);
  assign sel_reg = 3'(idx - pmdb_pkg::PMDB_IDX_CTRL0);
  // Ack drops for one cycle so each request is taken once
  assign acc = wb_cyc_i & wb_stb_i & ~ack_ff;

  // Register writes, lane 0 only; masked bits stay zero
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      for (int i = 0; i < pmdb_pkg::PMDB_NREG; i++) begin
        reg_ff[i] <= pmdb_pkg::PMDB_RESET;
      end
    end else if (acc && wb_we_i && hit && wb_sel_i[0]) begin
      reg_ff[sel_reg] <= wb_dat_i[7:0] & mask[sel_reg];
    end
  end

  // Acknowledge every access, mapped or not, one cycle after strobe
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_ff <= 1'b0;
    end else begin
      ack_ff <= acc;
    end
  end

  // Read data; unmapped addresses read zero
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rdat_ff <= 32'h0000_0000;
    end else if (acc && !wb_we_i) begin
      rdat_ff <= hit ? {24'h00_0000, reg_ff[sel_reg] & mask[sel_reg]}
                     : 32'h0000_0000;
    end
  end

  assign wb_ack_o = ack_ff;
  assign wb_dat_o = rdat_ff;

  // Flatten disable bits into one per-module vector
  // 0 vref,1 mem,2 refclk,3 pinchg,4..10 timers,11 nco,
  // 12..16 zcd cmp1 cmp2 adc dac, 17..22 ccp1..4 pwm6 pwm7,
  // 23..24 wg1 wg2, 25 sync, 26 async, 27 dsm, 28..31 cells 1..4
  assign off_vec[0]     = reg_ff[0][pmdb_pkg::PMDB_B_VREF];
  assign off_vec[1]     = reg_ff[0][pmdb_pkg::PMDB_B_MEM];
  assign off_vec[2]     = reg_ff[0][pmdb_pkg::PMDB_B_REFCLK];
  assign off_vec[3]     = reg_ff[0][pmdb_pkg::PMDB_B_PINCHG];
  assign off_vec[10:4]  = reg_ff[1][6:0];
  assign off_vec[11]    = reg_ff[2][pmdb_pkg::PMDB_B_NCO];
  assign off_vec[12]    = reg_ff[3][pmdb_pkg::PMDB_B_ZCD];
  assign off_vec[13]    = reg_ff[3][pmdb_pkg::PMDB_B_CMP1];
  assign off_vec[14]    = reg_ff[3][pmdb_pkg::PMDB_B_CMP2];
  assign off_vec[15]    = reg_ff[3][pmdb_pkg::PMDB_B_ADC];
  assign off_vec[16]    = reg_ff[3][pmdb_pkg::PMDB_B_DAC];
  assign off_vec[20:17] = reg_ff[4][3:0];
  assign off_vec[21]    = reg_ff[4][pmdb_pkg::PMDB_B_PWM6];
  assign off_vec[22]    = reg_ff[4][pmdb_pkg::PMDB_B_PWM7];
  assign off_vec[23]    = reg_ff[5][pmdb_pkg::PMDB_B_WG1];
  assign off_vec[24]    = reg_ff[5][pmdb_pkg::PMDB_B_WG2];
  assign off_vec[25]    = reg_ff[6][pmdb_pkg::PMDB_B_SSER];
  assign off_vec[26]    = reg_ff[6][pmdb_pkg::PMDB_B_ASER];
  assign off_vec[27]    = reg_ff[7][pmdb_pkg::PMDB_B_DSM];
  assign off_vec[31:28] = reg_ff[7][4:1];

  // Per-module reset stretch and access filter
  genvar g;
  generate
    for (g = 0; g < 32; g++) begin : g_mod
      pmdb_wake #(
        .CYC    (WAKE_CYC)
      ) u_wake (
        .clk_i  (clk_i),
        .rst_i  (rst_i),
        .off_i  (off_vec[g]),
        .hold_o (hold_vec[g])
      );
      // Writes refused and reads zero while disabled
      assign mod_wr_ok_o[g] = mod_wr_req_i[g] & ~off_vec[g];
      assign mod_rd_dat_o[g*8 +: 8] =
        off_vec[g] ? 8'h00 : mod_rd_dat_i[g*8 +: 8];
      assign mod_dout_o[g] = mod_dout_i[g] & ~off_vec[g];
    end
  endgenerate

  // Measurement timer sits outside the flat vector but restarts the same
  pmdb_wake #(
    .CYC    (WAKE_CYC)
  ) u_smt_wake (
    .clk_i  (clk_i),
    .rst_i  (rst_i),
    .off_i  (reg_ff[7][pmdb_pkg::PMDB_B_SMT]),
    .hold_o (smt_hold)
  );

  // Clock gates follow the disable bit directly, resets are stretched
  assign sysclk_en_o      = ~reg_ff[0][pmdb_pkg::PMDB_B_SYSCLK];
  assign vref_clk_en_o    = ~off_vec[0];
  assign mem_clk_en_o     = ~off_vec[1];
  assign refclk_clk_en_o  = ~off_vec[2];
  assign pinchg_clk_en_o  = ~off_vec[3];
  assign timer_clk_en_o   = ~off_vec[10:4];
  assign nco_clk_en_o     = ~off_vec[11];
  assign ana_clk_en_o     = ~off_vec[16:12];
  assign pwm_clk_en_o     = ~off_vec[22:17];
  assign wavegen_clk_en_o = ~off_vec[24:23];
  assign serial_clk_en_o  = ~off_vec[26:25];
  assign logic_clk_en_o   = {reg_ff[7][pmdb_pkg::PMDB_B_SMT],
                             off_vec[31:28], off_vec[27]} ^ 6'h3f;
  assign vref_rst_o       = hold_vec[0];
  assign mem_rst_o        = hold_vec[1];
  assign refclk_rst_o     = hold_vec[2];
  assign pinchg_rst_o     = hold_vec[3];
  assign timer_rst_o      = hold_vec[10:4];
  assign nco_rst_o        = hold_vec[11];
  assign ana_rst_o        = hold_vec[16:12];
  assign pwm_rst_o        = hold_vec[22:17];
  assign wavegen_rst_o    = hold_vec[24:23];
  assign serial_rst_o     = hold_vec[26:25];
  assign logic_rst_o      = {smt_hold,
                             hold_vec[31:28], hold_vec[27]};

  // Memory settle counter: reports when data access is safe again
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mem_cnt_ff <= '0;
    end else if (off_vec[1]) begin
      mem_cnt_ff <= ($clog2(MEM_WAKE_CYC+1))'(MEM_WAKE_CYC);
    end else if (mem_cnt_ff != '0) begin
      mem_cnt_ff <= mem_cnt_ff - 1'b1;
    end
  end

  // Memory controller blocked while off
  assign mem_grant_o     = mem_req_i & ~off_vec[1];
  assign mem_ctl_wr_ok_o = mem_ctl_wr_i & ~off_vec[1];
  assign mem_ptr_rd_o    = off_vec[1] ? 8'h00 : mem_ptr_rd_i;
  assign mem_ready_o     = ~off_vec[1] && (mem_cnt_ff == '0);
endmodule : pmdb_bank
`default_nettype wire

// ### sim/pmdb_bank_sva.sv
// Checker for the module disable bank, bound to its top ports.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/1ps
`default_nettype none
module pmdb_bank_sva (
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [13:0] wb_adr_i,
  input wire logic [3:0]  wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  input wire logic        sysclk_en_o,
  input wire logic        vref_clk_en_o,
  input wire logic        mem_clk_en_o,
  input wire logic [6:0]  timer_clk_en_o,
  input wire logic [6:0]  timer_rst_o,
  input wire logic [31:0] mod_dout_i,
  input wire logic [31:0] mod_dout_o,
  input wire logic        mem_req_i,
  input wire logic        mem_grant_o,
  input wire logic [7:0]  mem_ptr_rd_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // Request accepted at this edge
  wire logic take = wb_cyc_i && wb_stb_i && !wb_ack_o;
  // Write to control register 0 with its byte lane on
  sequence wr0;
    take && wb_we_i && wb_sel_i[0] && wb_adr_i == 14'h1e58;
  endsequence
  a_ack_one_cycle: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  a_ack_after_take: assert property (take |=> wb_ack_o)
    else $error("ack missing after request");
  a_sysclk_gate_wr: assert property (
    wr0 |=> sysclk_en_o == !$past(wb_dat_i[7]))
    else $error("system clock gate wrong");
  a_vref_gate_wr: assert property (
    wr0 |=> vref_clk_en_o == !$past(wb_dat_i[6]))
    else $error("reference gate wrong");
  a_mem_grant_gate: assert property (
    mem_grant_o == (mem_req_i && mem_clk_en_o))
    else $error("memory grant wrong");
  a_mem_ptr_zero: assert property (
    !mem_clk_en_o |-> mem_ptr_rd_o == 8'h00)
    else $error("pointer read not zero");
  a_dout_filter_off: assert property (
    mod_dout_o[4] == (mod_dout_i[4] && timer_clk_en_o[0]))
    else $error("timer output not filtered");
  a_rst_while_off: assert property (
    !timer_clk_en_o[0] |-> timer_rst_o[0])
    else $error("disabled timer not in reset");
  a_rst_after_on: assert property (
    $rose(timer_clk_en_o[0]) |-> timer_rst_o[0] [*4] ##[1:4] !timer_rst_o[0])
    else $error("timer reset hold wrong");
  a_reset_all_on: assert property (
    $fell(rst_i) |-> sysclk_en_o && (&timer_clk_en_o) && mem_clk_en_o)
    else $error("module not enabled after reset");
  a_unmapped_zero: assert property (take && !wb_we_i
    && (wb_adr_i < 14'h1e58 || wb_adr_i > 14'h1e77) |=> wb_dat_o == 32'h0)
    else $error("unmapped read not zero");
  c_reg0_write: cover property (wr0);
  c_timer_on: cover property ($rose(timer_clk_en_o[0]));
  c_mem_blocked: cover property (!mem_clk_en_o && mem_req_i);
endmodule : pmdb_bank_sva
bind pmdb_bank pmdb_bank_sva pmdb_bank_sva_inst (.*);
`default_nettype wire

// ### sim/pmdb_periph.sv
// Peripheral side model: register traffic, outputs and memory requests.
// Assumes the bank's filter is combinational; patterns move every cycle.
`timescale 1ns/1ps
`default_nettype none
module pmdb_periph (
  input  wire logic    clk_i,
  input  wire logic    rst_i,
  output logic [31:0]  wr_req_o,
  output logic [255:0] rd_dat_o,
  output logic [31:0]  dout_o,
  output logic         mem_req_o,
  output logic         mem_ctl_wr_o,
  output logic [7:0]   ptr_rd_o
);
  logic [7:0] cnt_ff; // Pattern source, one driver only
  // Free counter so stale values never pass for live ones
  always_ff @(posedge clk_i) begin
    if (rst_i) cnt_ff <= 8'h00;
    else cnt_ff <= cnt_ff + 8'h01;
  end
  // Bit 4 of each byte kept high so a blocked timer 0 shows
  assign wr_req_o = {4{cnt_ff | 8'h10}};
  assign dout_o = {4{cnt_ff | 8'h10}};
  assign rd_dat_o = {32{cnt_ff | 8'h01}}; // Never zero
  assign ptr_rd_o = cnt_ff | 8'h01;
  assign mem_req_o = 1'b1; // Memory always asked for
  assign mem_ctl_wr_o = 1'b1;
endmodule : pmdb_periph
`default_nettype wire

// ### sim/pmdb_bank_test.sv
// Self-checking bench for the module disable bank on classic Wishbone.
// Assumes one-cycle ack and WAKE_CYC of 4; memory settle shortened to 3.
`timescale 1ns/1ps
`default_nettype none
module pmdb_bank_test;
  localparam logic [11:0] B = pmdb_pkg::PMDB_IDX_CTRL0;
  localparam logic [7:0] MASKS [8] = '{pmdb_pkg::PMDB_MASK0,
    pmdb_pkg::PMDB_MASK1, pmdb_pkg::PMDB_MASK2, pmdb_pkg::PMDB_MASK3,
    pmdb_pkg::PMDB_MASK4, pmdb_pkg::PMDB_MASK5, pmdb_pkg::PMDB_MASK6,
    pmdb_pkg::PMDB_MASK7};
  logic clk_i = 1'b0, rst_i = 1'b1;
  logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
  logic [13:0] wb_adr_i = 14'h0000;
  logic [3:0] wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o;
  logic wb_ack_o, sysclk_en_o, vref_clk_en_o, mem_clk_en_o;
  logic refclk_clk_en_o, pinchg_clk_en_o, nco_clk_en_o, nco_rst_o;
  logic vref_rst_o, mem_rst_o, refclk_rst_o, pinchg_rst_o;
  logic [6:0] timer_clk_en_o, timer_rst_o;
  logic [4:0] ana_clk_en_o, ana_rst_o;
  logic [5:0] pwm_clk_en_o, logic_clk_en_o, pwm_rst_o, logic_rst_o;
  logic [1:0] wavegen_clk_en_o, serial_clk_en_o, wavegen_rst_o, serial_rst_o;
  logic [31:0] mod_wr_req_i, mod_wr_ok_o, mod_dout_i, mod_dout_o;
  logic [255:0] mod_rd_dat_i, mod_rd_dat_o;
  logic mem_req_i, mem_grant_o, mem_ctl_wr_i, mem_ctl_wr_ok_o, mem_ready_o;
  logic [7:0] mem_ptr_rd_i, mem_ptr_rd_o;
  logic [33:0] gate; // All clock enables, high runs
  logic [32:0] rstv; // All held resets
  int mismatches = 0, checks_done = 0;
  assign gate = {sysclk_en_o, vref_clk_en_o, mem_clk_en_o, refclk_clk_en_o,
    pinchg_clk_en_o, timer_clk_en_o, nco_clk_en_o, ana_clk_en_o,
    pwm_clk_en_o, wavegen_clk_en_o, serial_clk_en_o, logic_clk_en_o};
  assign rstv = {vref_rst_o, mem_rst_o, refclk_rst_o, pinchg_rst_o,
    timer_rst_o, nco_rst_o, ana_rst_o, pwm_rst_o, wavegen_rst_o,
    serial_rst_o, logic_rst_o};
  pmdb_bank #(.MEM_WAKE_CYC(3)) pmdb_bank_inst (.*);
  pmdb_periph pmdb_periph_inst (.clk_i(clk_i), .rst_i(rst_i),
    .wr_req_o(mod_wr_req_i), .rd_dat_o(mod_rd_dat_i), .dout_o(mod_dout_i),
    .mem_req_o(mem_req_i), .mem_ctl_wr_o(mem_ctl_wr_i),
    .ptr_rd_o(mem_ptr_rd_i));
  // 50 MHz clock
  initial begin
    forever #10 clk_i = ~clk_i;
  end
  task automatic summarize();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : summarize
  task automatic chk(input string what, input logic [33:0] e, logic [33:0] g);
    checks_done++;
    if (g !== e) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", what, e, g);
    end
  endtask : chk
  // Settled sampling point, away from the driving edge
  task automatic tick(input int n);
    repeat (n) @(negedge clk_i);
  endtask : tick
  // One classic cycle, held until ack is sampled high
  task automatic xfer(input logic we, logic [11:0] i, logic [7:0] d,
                      logic [3:0] sel, output logic [7:0] q);
    int n;
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= {i, 2'b00};
    wb_sel_i <= sel;
    wb_dat_i <= {24'h0, d};
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 20);
    if (n >= 20) begin
      mismatches++;
      summarize();
    end
    q = wb_dat_o[7:0];
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask : xfer
  task automatic wr(input logic [11:0] i, logic [7:0] d);
    logic [7:0] q;
    xfer(1'b1, i, d, 4'h1, q);
  endtask : wr
  task automatic rdc(input logic [11:0] i, logic [7:0] e);
    logic [7:0] q;
    xfer(1'b0, i, 8'h00, 4'h1, q);
    chk("read data", e, q);
  endtask : rdc
  task automatic t_reset();
    for (int i = 0; i < 8; i++) rdc(12'(B + i), 8'h00);
    chk("gates after reset", '1, gate);
    chk("resets after reset", 34'h0, rstv);
    $display("test reset done");
  endtask : t_reset
  // Every register filled, readback masked, off count per register
  task automatic t_masks();
    logic [7:0] q; // Unused read-back of the lane-off write
    for (int i = 0; i < 8; i++) begin
      wr(12'(B + i), 8'hff);
      rdc(12'(B + i), MASKS[i]);
      tick(1);
      chk("off count", $countones(MASKS[i]), 34 - $countones(gate));
      chk("reset count", $countones(MASKS[i]) - (i == 0), $countones(rstv));
      wr(12'(B + i), 8'h00);
      tick(1);
      chk("gates on again", '1, gate);
    end
    xfer(1'b1, 12'(B + 3), 8'hff, 4'h0, q);
    rdc(12'(B + 3), 8'h00);
    wr(12'h7a0, 8'hff);
    rdc(12'h7a0, 8'h00);
    $display("test masks done");
  endtask : t_masks
  // One field of register 0 at a time, top five gates compared
  task automatic t_reg0();
    logic [4:0] e;
    foreach (e[k]) begin
      e = 5'h1f & ~(5'h01 << k);
      wr(B, {e[4:3] ^ 2'b11, 3'b000, e[2:0] ^ 3'b111});
      tick(1);
      chk("reg0 gates", e, gate[33:29]);
      e = 5'h1f;
    end
    wr(B, 8'h00);
    $display("test reg0 done");
  endtask : t_reg0
  task automatic t_mem();
    int n;
    wr(B, 8'h04);
    tick(1);
    chk("mem blocked", 4'h0, {mem_grant_o, mem_ctl_wr_ok_o, mem_ready_o});
    chk("pointer zero", 8'h00, mem_ptr_rd_o);
    wr(B, 8'h00);
    for (n = 0; n < 30 && mem_ready_o !== 1'b1; n++) tick(1);
    chk("mem ready", 1'b1, mem_ready_o);
    chk("mem granted", 2'b11, {mem_grant_o, mem_ctl_wr_ok_o});
    $display("test mem done");
  endtask : t_mem
  task automatic t_timer();
    int n;
    wr(12'(B + 1), 8'h01);
    tick(1);
    chk("timer gates", 7'h7e, timer_clk_en_o);
    chk("filtered", 10'h0, {mod_wr_ok_o[4], mod_rd_dat_o[39:32], mod_dout_o[4]});
    chk("neighbour read", mod_rd_dat_i[47:40], mod_rd_dat_o[47:40]);
    wr(12'(B + 1), 8'h00);
    tick(1);
    chk("held after on", 2'b11, {timer_rst_o[0], timer_clk_en_o[0]});
    for (n = 0; n < 12 && timer_rst_o[0] === 1'b1; n++) tick(1);
    chk("hold length", 2'b10, {n >= 2, timer_rst_o[0]});
    chk("read restored", mod_rd_dat_i[39:32], mod_rd_dat_o[39:32]);
    $display("test timer done");
  endtask : t_timer
  // Reset in mid-run clears a written register
  task automatic t_rerst();
    wr(12'(B + 6), 8'h11);
    @(posedge clk_i);
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    rdc(12'(B + 6), 8'h00);
    $display("test second reset done");
  endtask : t_rerst
  initial begin
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    t_reset();
    t_masks();
    t_reg0();
    t_mem();
    t_timer();
    t_rerst();
    summarize();
  end
endmodule : pmdb_bank_test
`default_nettype wire
